// [hdl/pfcc_defs.vh]
// command codes, addresses and timing counts for the parallel flash host controller
`ifndef PFCC_DEFS_VH
`define PFCC_DEFS_VH
`define PFCC_ADDR_UNLOCK1 16'h5555
`define PFCC_ADDR_UNLOCK2 16'h2aaa
`define PFCC_DATA_UNLOCK1 8'haa
`define PFCC_DATA_UNLOCK2 8'h55
`define PFCC_DATA_SETUP 8'h80
`define PFCC_DATA_ERASE 8'h10
`define PFCC_DATA_LOCK 8'h40
`define PFCC_DATA_PROGRAM 8'ha0
`define PFCC_DATA_ID_ENTER 8'h90
`define PFCC_DATA_ID_EXIT 8'hf0
`define PFCC_ADDR_LOCK_STATUS 16'h0002
`define PFCC_LOCK_STATUS_BIT 0
`define PFCC_POLL_STATUS_BIT 7
`define PFCC_ERASED_BYTE 8'hff
`define PFCC_BOOT_LAST 16'h1fff
`define PFCC_CLK_MHZ 40
`define PFCC_STROBE_NS 100
`define PFCC_STROBE_CYC ((`PFCC_STROBE_NS * `PFCC_CLK_MHZ + 999) / 1000)
`define PFCC_BYTE_PROGRAM_US 30
`define PFCC_BYTE_PROGRAM_CYC (`PFCC_BYTE_PROGRAM_US * `PFCC_CLK_MHZ)
`define PFCC_CHIP_ERASE_S 10
`define PFCC_CHIP_ERASE_CYC (`PFCC_CHIP_ERASE_S * 1000000 * `PFCC_CLK_MHZ)
`define PFCC_OP_READ 3'h0
`define PFCC_OP_PROGRAM 3'h1
`define PFCC_OP_ERASE 3'h2
`define PFCC_OP_LOCK 3'h3
`define PFCC_OP_LOCK_CHECK 3'h4
`define PFCC_OP_ID_EXIT 3'h5
`endif

// [hdl/pfcc_bus_cycle.v]
// one strobed bus access (write or read) on the flash pins
`timescale 1ns/1ps
`include "pfcc_defs.vh"
module pfcc_bus_cycle #(
  parameter STROBE_CYC = `PFCC_STROBE_CYC
) (
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire start_i,
  input wire write_i,
  input wire [15:0] addr_i,
  input wire [7:0] wdata_i,
  input wire [7:0] data_in_i,
  output reg done_o,
  output reg [7:0] rdata_o,
  output reg [15:0] address_lines_o,
  output reg [7:0] data_lines_o,
  output reg data_lines_oe_o,
  output reg chip_sel_n_o,
  output reg out_en_n_o,
  output reg wr_n_o
);
  localparam S_IDLE = 2'd0;
  localparam S_SETUP = 2'd1;
  localparam S_STROBE = 2'd2;
  localparam S_HOLD = 2'd3;
  reg [1:0] state_q;
  reg [15:0] cnt_q;
  reg write_q;
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state_q <= S_IDLE;
      cnt_q <= 16'h0000;
      write_q <= 1'b0;
      done_o <= 1'b0;
      rdata_o <= 8'h00;
      address_lines_o <= 16'h0000;
      data_lines_o <= 8'h00;
      data_lines_oe_o <= 1'b0;
      chip_sel_n_o <= 1'b1;
      out_en_n_o <= 1'b1;
      wr_n_o <= 1'b1;
    end else begin
      done_o <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (start_i) begin
            // address settles a cycle before any strobe falls
            address_lines_o <= addr_i;
            data_lines_o <= wdata_i;
            data_lines_oe_o <= write_i;
            write_q <= write_i;
            state_q <= S_SETUP;
          end
        end
        S_SETUP: begin
          // chip select and strobe fall together; address already stable
          chip_sel_n_o <= 1'b0;
          wr_n_o <= ~write_q;
          out_en_n_o <= write_q;
          cnt_q <= STROBE_CYC[15:0];
          state_q <= S_STROBE;
        end
        S_STROBE: begin
          if (cnt_q <= 16'h0001) begin
            // data held across the rising strobe edge
            wr_n_o <= 1'b1;
            out_en_n_o <= 1'b1;
            chip_sel_n_o <= 1'b1;
            rdata_o <= data_in_i;
            state_q <= S_HOLD;
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
        S_HOLD: begin
          data_lines_oe_o <= 1'b0;
          done_o <= 1'b1;
          state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
endmodule

// [hdl/pfcc_host.v]
// host controller sequencing commands, reads and polling on a parallel flash
// Contract
// - erase before reprogramming any byte (not checked by the host; a mismatched read-back sets error_o)
// - chip erase via six-write sequence
// - program is four writes, last carries target
// - new access only after program ends (after a poll timeout the host sets error_o and takes new requests)
// - lockout via six-write sequence
// - exit id mode after lock check
// - unlock aa/55, 80 setup, 10 erase, 40 lock
// - id entry 90, exit by f0
`timescale 1ns/1ps
`include "pfcc_defs.vh"
module pfcc_host #(
  parameter PROGRAM_TIMEOUT_CYC = `PFCC_BYTE_PROGRAM_CYC * 4,
  parameter ERASE_TIMEOUT_CYC = `PFCC_CHIP_ERASE_CYC,
  parameter STROBE_CYC = `PFCC_STROBE_CYC
) (
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire req_i,
  input wire [2:0] op_i,
  input wire [15:0] addr_i,
  input wire [7:0] wdata_i,
  input wire [7:0] data_lines_i,
  output reg busy_o,
  output reg done_o,
  output reg error_o,
  output reg [7:0] rdata_o,
  output reg lock_status_o,
  output wire [15:0] address_lines_o,
  output wire [7:0] data_lines_o,
  output wire data_lines_oe_o,
  output wire chip_sel_n_o,
  output wire out_en_n_o,
  output wire wr_n_o
);
  localparam S_IDLE = 3'd0;
  localparam S_ISSUE = 3'd1;
  localparam S_WAIT = 3'd2;
  localparam S_POLL = 3'd3;
  localparam S_POLL_WAIT = 3'd4;
  localparam S_FINISH = 3'd5;
  reg [2:0] state_q;
  reg [2:0] op_q;
  reg [2:0] step_q;
  reg [15:0] addr_q;
  reg [7:0] wdata_q;
  reg [31:0] timer_q;
  reg cyc_start_q;
  reg cyc_write_q;
  reg [15:0] cyc_addr_q;
  reg [7:0] cyc_data_q;
  reg [2:0] len_d;
  reg [15:0] step_addr_d;
  reg [7:0] step_data_d;
  reg step_write_d;
  wire cyc_done;
  wire [7:0] cyc_rdata;
  wire last_step;
  wire [7:0] poll_expect;
  pfcc_bus_cycle #(
    .STROBE_CYC(STROBE_CYC)
  ) u_cycle (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .start_i(cyc_start_q),
    .write_i(cyc_write_q),
    .addr_i(cyc_addr_q),
    .wdata_i(cyc_data_q),
    .data_in_i(data_lines_i),
    .done_o(cyc_done),
    .rdata_o(cyc_rdata),
    .address_lines_o(address_lines_o),
    .data_lines_o(data_lines_o),
    .data_lines_oe_o(data_lines_oe_o),
    .chip_sel_n_o(chip_sel_n_o),
    .out_en_n_o(out_en_n_o),
    .wr_n_o(wr_n_o)
  );
  // sequence length and per-step address/data for the latched operation
  always @* begin
    len_d = 3'd1;
    step_write_d = 1'b1;
    step_addr_d = `PFCC_ADDR_UNLOCK1;
    step_data_d = `PFCC_DATA_UNLOCK1;
    case (op_q)
      `PFCC_OP_PROGRAM: len_d = 3'd4;
      `PFCC_OP_ERASE: len_d = 3'd6;
      `PFCC_OP_LOCK: len_d = 3'd6;
      `PFCC_OP_LOCK_CHECK: len_d = 3'd5;
      `PFCC_OP_ID_EXIT: len_d = 3'd1;
      default: len_d = 3'd1;
    endcase
    case (step_q)
      3'd0, 3'd3: begin
        step_addr_d = `PFCC_ADDR_UNLOCK1;
        step_data_d = `PFCC_DATA_UNLOCK1;
      end
      3'd1, 3'd4: begin
        step_addr_d = `PFCC_ADDR_UNLOCK2;
        step_data_d = `PFCC_DATA_UNLOCK2;
      end
      3'd2: begin
        step_addr_d = `PFCC_ADDR_UNLOCK1;
        case (op_q)
          `PFCC_OP_PROGRAM: step_data_d = `PFCC_DATA_PROGRAM;
          `PFCC_OP_LOCK_CHECK: step_data_d = `PFCC_DATA_ID_ENTER;
          default: step_data_d = `PFCC_DATA_SETUP;
        endcase
      end
      default: begin
        step_addr_d = `PFCC_ADDR_UNLOCK1;
        step_data_d = `PFCC_DATA_UNLOCK1;
      end
    endcase
    if (op_q == `PFCC_OP_PROGRAM && step_q == 3'd3) begin
      step_addr_d = addr_q;
      step_data_d = wdata_q;
    end
    if (op_q == `PFCC_OP_ERASE && step_q == 3'd5) begin
      step_data_d = `PFCC_DATA_ERASE;
    end
    if (op_q == `PFCC_OP_LOCK && step_q == 3'd5) begin
      step_data_d = `PFCC_DATA_LOCK;
    end
    if (op_q == `PFCC_OP_LOCK_CHECK && step_q == 3'd3) begin
      step_write_d = 1'b0;
      step_addr_d = `PFCC_ADDR_LOCK_STATUS;
    end
    if (op_q == `PFCC_OP_LOCK_CHECK && step_q == 3'd4) begin
      step_data_d = `PFCC_DATA_ID_EXIT;
    end
    if (op_q == `PFCC_OP_ID_EXIT) begin
      step_data_d = `PFCC_DATA_ID_EXIT;
    end
    if (op_q == `PFCC_OP_READ) begin
      step_write_d = 1'b0;
      step_addr_d = addr_q;
    end
  end
  assign last_step = (step_q == len_d - 3'd1);
  assign poll_expect = wdata_q;
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state_q <= S_IDLE;
      op_q <= `PFCC_OP_READ;
      step_q <= 3'd0;
      addr_q <= 16'h0000;
      wdata_q <= 8'h00;
      timer_q <= 32'h00000000;
      cyc_start_q <= 1'b0;
      cyc_write_q <= 1'b0;
      cyc_addr_q <= 16'h0000;
      cyc_data_q <= 8'h00;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      error_o <= 1'b0;
      rdata_o <= 8'h00;
      lock_status_o <= 1'b0;
    end else begin
      cyc_start_q <= 1'b0;
      done_o <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (req_i) begin
            // requests arriving while busy are dropped, so software must wait for done
            op_q <= op_i;
            addr_q <= addr_i;
            wdata_q <= wdata_i;
            step_q <= 3'd0;
            busy_o <= 1'b1;
            error_o <= 1'b0;
            state_q <= S_ISSUE;
          end
        end
        S_ISSUE: begin
          cyc_start_q <= 1'b1;
          cyc_write_q <= step_write_d;
          cyc_addr_q <= step_addr_d;
          cyc_data_q <= step_data_d;
          state_q <= S_WAIT;
        end
        S_WAIT: begin
          if (cyc_done) begin
            if (!step_write_d) begin
              rdata_o <= cyc_rdata;
              if (op_q == `PFCC_OP_LOCK_CHECK) begin
                lock_status_o <= cyc_rdata[`PFCC_LOCK_STATUS_BIT];
              end
            end
            if (last_step) begin
              timer_q <= 32'h00000000;
              if (op_q == `PFCC_OP_PROGRAM || op_q == `PFCC_OP_ERASE ||
                  op_q == `PFCC_OP_LOCK) begin
                state_q <= S_POLL;
              end else begin
                state_q <= S_FINISH;
              end
            end else begin
              step_q <= step_q + 3'd1;
              state_q <= S_ISSUE;
            end
          end
        end
        S_POLL: begin
          // erase and lock poll for a set bit 7 at the first unlock address, not the target address
          cyc_start_q <= 1'b1;
          cyc_write_q <= 1'b0;
          cyc_addr_q <= (op_q == `PFCC_OP_PROGRAM) ? addr_q : `PFCC_ADDR_UNLOCK1;
          state_q <= S_POLL_WAIT;
        end
        S_POLL_WAIT: begin
          timer_q <= timer_q + 32'h00000001;
          if (cyc_done) begin
            rdata_o <= cyc_rdata;
            if (op_q == `PFCC_OP_PROGRAM &&
                cyc_rdata[`PFCC_POLL_STATUS_BIT] == poll_expect[`PFCC_POLL_STATUS_BIT]) begin
              // bit 7 matching bit 7 of the written data means the program cycle has ended
              error_o <= (cyc_rdata != wdata_q);
              state_q <= S_FINISH;
            end else if (op_q != `PFCC_OP_PROGRAM &&
                         cyc_rdata[`PFCC_POLL_STATUS_BIT]) begin
              state_q <= S_FINISH;
            end else if ((op_q == `PFCC_OP_PROGRAM && timer_q >= PROGRAM_TIMEOUT_CYC) ||
                         (op_q != `PFCC_OP_PROGRAM && timer_q >= ERASE_TIMEOUT_CYC)) begin
              error_o <= 1'b1;
              state_q <= S_FINISH;
            end else begin
              state_q <= S_POLL;
            end
          end
        end
        S_FINISH: begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
          state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
endmodule

// [tb/pfcc_host_chk.sv]
// port assertions for the parallel flash host controller
`timescale 1ns/1ps
`include "pfcc_defs.vh"
module pfcc_host_chk (
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire req_i,
  input wire [2:0] op_i,
  input wire busy_o,
  input wire done_o,
  input wire error_o,
  input wire [15:0] address_lines_o,
  input wire [7:0] data_lines_o,
  input wire data_lines_oe_o,
  input wire chip_sel_n_o,
  input wire out_en_n_o,
  input wire wr_n_o
);
  wire taken = req_i && !busy_o && !done_o;
  wire first_w = !wr_n_o && address_lines_o == 16'h5555 && data_lines_o == 8'haa;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  no_contend_a: assert property (!out_en_n_o |-> !data_lines_oe_o && wr_n_o)
    else $error("host drives data during a read");
  addr_hold_a: assert property (!chip_sel_n_o && $past(!chip_sel_n_o) |-> $stable(address_lines_o))
    else $error("address moved while selected");
  data_hold_a: assert property (!wr_n_o && $past(!wr_n_o) |-> data_lines_oe_o && $stable(data_lines_o))
    else $error("write data moved under strobe");
  strobe_width_a: assert property ($fell(wr_n_o) |-> (!wr_n_o && !chip_sel_n_o)[*4])
    else $error("write strobe too short");
  erase_seq_a: assert property (taken && op_i == `PFCC_OP_ERASE |-> ##[1:12] first_w)
    else $error("erase unlock write missing");
  prog_seq_a: assert property (taken && op_i == `PFCC_OP_PROGRAM |-> ##[1:12] first_w)
    else $error("program unlock write missing");
  id_exit_a: assert property (taken && op_i == `PFCC_OP_ID_EXIT
    |-> ##[1:12] (!wr_n_o && data_lines_o == 8'hf0))
    else $error("id exit write missing");
  busy_rise_a: assert property (taken |=> busy_o)
    else $error("busy not raised");
  done_quiet_a: assert property (done_o |-> chip_sel_n_o && wr_n_o ##1 !done_o)
    else $error("done while bus active");
  error_done_a: assert property ($rose(error_o) |=> done_o)
    else $error("error outside completion");
  cover property (taken && op_i == `PFCC_OP_PROGRAM);
  cover property (taken && op_i == `PFCC_OP_ERASE);
  cover property (taken && op_i == `PFCC_OP_LOCK_CHECK);
endmodule
bind pfcc_host pfcc_host_chk u_chk (.*);

// [tb/pfcc_flash_model.sv]
// behavioural parallel flash device facing the host controller
`timescale 1ns/1ps
module pfcc_flash_model (
  input wire [15:0] address_lines_i,
  input wire [7:0] data_lines_i,
  input wire chip_sel_n_i,
  input wire out_en_n_i,
  input wire wr_n_i,
  output wire [7:0] data_lines_o
);
  reg [7:0] mem [0:65535];
  reg [2:0] step;
  reg id_q, lock_q, busy_q;
  reg [15:0] la;
  reg [7:0] pd, last;
  integer prog_ns, erase_ns, i;
  wire [7:0] d = data_lines_i;
  wire at5 = la == 16'h5555;
  wire wstb = chip_sel_n_i | wr_n_i;
  wire rd_en = !chip_sel_n_i && !out_en_n_i && wr_n_i;
  wire [7:0] rd = busy_q ? ~pd :
    id_q ? {7'h00, lock_q && address_lines_i == 16'h0002} : mem[address_lines_i];
  // released lines show the inverse of the last byte, never a stale copy
  assign data_lines_o = rd_en ? rd : ~last;
  initial begin
    step = 0; id_q = 0; lock_q = 0; busy_q = 0; last = 0; pd = 0; la = 0;
    prog_ns = 1000;
    erase_ns = 500;
    for (i = 0; i < 65536; i = i + 1) mem[i] = 8'hff;
  end
  always @(posedge chip_sel_n_i or posedge out_en_n_i) last = rd;
  always @(negedge wstb) la = address_lines_i;
  always @(posedge wstb) begin
    if (step == 3) begin
      step = 0;
      if (!(lock_q && la <= 16'h1fff)) begin
        mem[la] = mem[la] & d;
        pd = d;
        busy_q = 1;
        busy_q <= #(prog_ns) 0;
      end
    end else if (step == 0 && d == 8'hf0) id_q = 0;
    else if ((step == 0 || step == 4) && at5 && d == 8'haa) step = step + 1;
    else if ((step == 1 || step == 5) && la == 16'h2aaa && d == 8'h55) step = step + 1;
    else if (step == 2 && at5 && d == 8'ha0) step = 3;
    else if (step == 2 && at5 && d == 8'h80) step = 4;
    else if (step == 2 && at5 && (d == 8'h90 || d == 8'hf0)) begin
      id_q = (d == 8'h90);
      step = 0;
    end else if (step == 6 && at5 && d == 8'h10) begin
      step = 0;
      for (i = 0; i < 65536; i = i + 1) if (!(lock_q && i <= 16'h1fff)) mem[i] = 8'hff;
      pd = 8'hff;
      busy_q = 1;
      busy_q <= #(erase_ns) 0;
    end else if (step == 6 && at5 && d == 8'h40) begin
      step = 0;
      lock_q = 1;
    end else step = 0;
  end
endmodule

// [tb/pfcc_host_test.sv]
// self-checking bench for the parallel flash host controller
`timescale 1ns/1ps
`include "pfcc_defs.vh"
module pfcc_host_test;
  reg ref_clk_i = 0;
  reg rst_n_i = 0;
  reg req_i = 0;
  reg [2:0] op_i = 0;
  reg [15:0] addr_i = 0;
  reg [7:0] wdata_i = 0;
  wire busy_o, done_o, error_o, lock_status_o, dl_oe, cs_n, oe_n, wr_n;
  wire [7:0] rdata_o, host_dl, dev_dl;
  wire [15:0] addr_l;
  wire [7:0] bus_dl = dl_oe ? host_dl : dev_dl;
  integer fails = 0, tests_run = 0, cycles = 0;
  always #12.5 ref_clk_i = ~ref_clk_i;
  pfcc_host #(.PROGRAM_TIMEOUT_CYC(100), .ERASE_TIMEOUT_CYC(200)) dut (.ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .req_i(req_i), .op_i(op_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .data_lines_i(bus_dl), .busy_o(busy_o), .done_o(done_o), .error_o(error_o),
    .rdata_o(rdata_o), .lock_status_o(lock_status_o), .address_lines_o(addr_l),
    .data_lines_o(host_dl), .data_lines_oe_o(dl_oe), .chip_sel_n_o(cs_n),
    .out_en_n_o(oe_n), .wr_n_o(wr_n));
  pfcc_flash_model flash (.address_lines_i(addr_l), .data_lines_i(bus_dl),
    .chip_sel_n_i(cs_n), .out_en_n_i(oe_n), .wr_n_i(wr_n), .data_lines_o(dev_dl));
  task conclude;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  always @(posedge ref_clk_i) begin
    cycles = cycles + 1;
    if (cycles == 60000) begin
      fails = fails + 1;
      conclude;
    end
  end
  task chk(input [8*10:1] name, input [7:0] seen, input [7:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("FAIL %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task run(input [2:0] o, input [15:0] a, input [7:0] d);
    integer n;
    begin
      op_i = o; addr_i = a; wdata_i = d; req_i = 1;
      @(posedge ref_clk_i) #1;
      req_i = 0;
      chk("busy_on", {7'h00, busy_o}, 8'h01);
      n = 0;
      while (done_o !== 1'b1 && n < 3000) begin
        @(posedge ref_clk_i) #1;
        n = n + 1;
      end
      chk("done", {7'h00, done_o}, 8'h01);
      chk("busy_off", {7'h00, busy_o}, 8'h00);
      @(posedge ref_clk_i) #1;
    end
  endtask
  task t_program;
    begin
      run(`PFCC_OP_READ, 16'h3000, 0);
      chk("erased", rdata_o, 8'hff);
      run(`PFCC_OP_PROGRAM, 16'h3000, 8'ha5);
      chk("prog_err", {7'h00, error_o}, 8'h00);
      run(`PFCC_OP_READ, 16'h3000, 0);
      chk("prog_rd", rdata_o, 8'ha5);
      run(`PFCC_OP_PROGRAM, 16'h3000, 8'h5a);
      chk("repr_err", {7'h00, error_o}, 8'h01);
      run(`PFCC_OP_READ, 16'h3000, 0);
      chk("repr_rd", rdata_o, 8'h00);
      run(`PFCC_OP_ERASE, 0, 0);
      chk("ers_err", {7'h00, error_o}, 8'h00);
      run(`PFCC_OP_READ, 16'h3000, 0);
      chk("ers_rd", rdata_o, 8'hff);
    end
  endtask
  task t_lock;
    begin
      run(`PFCC_OP_PROGRAM, 16'h0100, 8'h3c);
      run(`PFCC_OP_LOCK_CHECK, 0, 0);
      chk("unlocked", {7'h00, lock_status_o}, 8'h00);
      run(`PFCC_OP_READ, 16'h0100, 0);
      chk("boot_rd", rdata_o, 8'h3c);
      run(`PFCC_OP_LOCK, 0, 0);
      run(`PFCC_OP_LOCK_CHECK, 0, 0);
      chk("locked", {7'h00, lock_status_o}, 8'h01);
      run(`PFCC_OP_ID_EXIT, 0, 0);
      run(`PFCC_OP_PROGRAM, 16'h1fff, 8'h00);
      chk("bt_err", {7'h00, error_o}, 8'h01);
      run(`PFCC_OP_READ, 16'h1fff, 0);
      chk("bt_rd", rdata_o, 8'hff);
      run(`PFCC_OP_PROGRAM, 16'h2000, 8'h11);
      chk("main_err", {7'h00, error_o}, 8'h00);
      run(`PFCC_OP_ERASE, 0, 0);
      run(`PFCC_OP_READ, 16'h0100, 0);
      chk("kept", rdata_o, 8'h3c);
      run(`PFCC_OP_READ, 16'h2000, 0);
      chk("main_ers", rdata_o, 8'hff);
    end
  endtask
  task t_slow;
    begin
      // device busy longer than the host's poll budget
      flash.prog_ns = 10000;
      run(`PFCC_OP_PROGRAM, 16'h4000, 8'h0f);
      chk("slow_err", {7'h00, error_o}, 8'h01);
      #12000;
      flash.prog_ns = 1000;
      run(`PFCC_OP_READ, 16'h4000, 0);
      chk("slow_rd", rdata_o, 8'h0f);
    end
  endtask
  initial begin
    repeat (5) @(posedge ref_clk_i);
    #1 rst_n_i = 1;
    t_program;
    t_lock;
    t_slow;
    conclude;
  end
endmodule
